// file: rtl/brs_decoder.sv
// boot region, remap and fast sram address decoder
//
// Behaviour
// - fast sram is five 16 KB blocks, each steered whole
// - one block always stays in the bus-matrix region
// - after reset all five blocks sit at 0x300000, order 4,3,2,1,0
// - 32K/32K: blocks 1,0 instruction_tcm; 3,2 data_tcm; 4 bus-matrix
// - reallocation moves blocks non-contiguously between regions
// - fast sram answers single-cycle from matrix and tcm ports
// - 16 KB sram decoded at 0x500000, single cycle
// - fetch starts at address zero showing the boot memory
// - remap set by software places internal sram at zero
// - remap clear: latched boot select picks rom or external
// - 0x0 to 0xFFFFF reserved for the boot mapping
// - boot select high maps embedded rom
// - boot select low maps external chip select 0
// - external boot: byte-select, 16-bit bus, cs-strobed access
// - unaffected memories stay at their own bases
// - each external chip select gets a 256 MB window
// - system controller decoded in top 16 KB
// - instruction_tcm and data_tcm sizes 0, 16 or 32 KB; rest to matrix
`timescale 1ns/100ps
`default_nettype none
module brs_decoder
	import brs_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic boot_select_pin_in,
	input wire logic remap_in,
	input wire logic [1:0] instruction_tcm_size_in,
	input wire logic [1:0] data_tcm_size_in,
	input wire logic req_valid_in,
	input wire logic [31:0] req_addr_in,
	input wire logic tcm_valid_in,
	input wire logic tcm_is_data_in,
	input wire logic [15:0] tcm_addr_in,
	output brs_route_s route_out,
	output logic route_valid_out,
	output logic [2:0] tcm_block_out,
	output logic [13:0] tcm_offset_out,
	output logic tcm_valid_out,
	output brs_smc_cfg_s smc_cfg_out,
	output logic boot_rom_out,
	output logic remap_out
);
	//------------------------------------------------------------
	// boot strap and remap state
	//------------------------------------------------------------
	wire logic boot_rom;
	wire logic strap_valid;
	brs_state_e state;
	brs_state_e next_state;

	brs_boot_latch u_latch (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.boot_select_pin_in(boot_select_pin_in),
		.boot_rom_out(boot_rom),
		.valid_out(strap_valid)
	);

	// remap only after the strap is known; clearing returns to boot map
	always_comb begin
		next_state = state;
		case (state)
			BRS_ST_RESET: next_state = strap_valid ? BRS_ST_RUN : state;
			BRS_ST_RUN: next_state = remap_in ? BRS_ST_REMAP : state;
			BRS_ST_REMAP: next_state = remap_in ? state : BRS_ST_RUN;
			default: next_state = BRS_ST_RESET;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			state <= BRS_ST_RESET;
		else
			state <= next_state;
	end

	//------------------------------------------------------------
	// matrix address decode
	//------------------------------------------------------------
	wire logic [31:0] a;
	wire logic in_boot;
	wire logic in_instruction_tcm;
	wire logic in_data_tcm;
	wire logic in_ahb;
	wire logic in_sram16;
	wire logic in_rom;
	wire logic in_sysc;
	wire logic [3:0] cs_num;
	wire logic in_cs;
	wire logic remapped;
	wire logic [2:0] slot;
	wire logic [1:0] region;
	wire logic [2:0] blk;

	assign a = req_addr_in;
	assign remapped = (state == BRS_ST_REMAP);
	assign in_boot = (a & REGION_MASK) == BOOT_BASE;
	assign in_instruction_tcm = (a & REGION_MASK) == INSTRUCTION_TCM_BASE;
	assign in_data_tcm = (a & REGION_MASK) == DATA_TCM_BASE;
	assign in_ahb = (a & REGION_MASK) == AHB_BASE;
	assign in_rom = (a & REGION_MASK) == ROM_BASE;
	assign in_sram16 = (a & SRAM16_MASK) == SRAM16_BASE;
	assign in_sysc = (a & SYSC_MASK) == SYSC_BASE;
	assign cs_num = a[31:CS_SHIFT];
	assign in_cs = (cs_num >= CS_FIRST) && (cs_num <= CS_LAST);
	assign slot = 3'(a[PAGE_W + 1:BLK_OFF_W]);
	// boot area after remap reads the ahb region from its base
	assign region = (in_instruction_tcm) ? 2'd0 : (in_data_tcm) ? 2'd1 : 2'd2;

	brs_block_map u_map (
		.instruction_tcm_size_in(instruction_tcm_size_in),
		.data_tcm_size_in(data_tcm_size_in),
		.region_in(region),
		.slot_in(a[19:17] == 3'd0 ? slot : BLK_NONE),
		.block_out(blk)
	);

	// boot area: remap wins, else the latched strap picks rom or cs0
	wire brs_sel_e boot_sel;
	assign boot_sel = remapped ? BRS_SEL_BOOTRAM :
		(boot_rom ? BRS_SEL_ROM : BRS_SEL_EXT);

	wire brs_sel_e next_sel;
	assign next_sel = in_boot ? boot_sel :
		(in_instruction_tcm && blk != BLK_NONE) ? BRS_SEL_INSTRUCTION_TCM :
		(in_data_tcm && blk != BLK_NONE) ? BRS_SEL_DATA_TCM :
		(in_ahb && blk != BLK_NONE) ? BRS_SEL_AHB :
		in_rom ? BRS_SEL_ROM :
		in_sram16 ? BRS_SEL_SRAM16 :
		in_sysc ? BRS_SEL_SYSC :
		in_cs ? BRS_SEL_OTHER : BRS_SEL_NONE;

	wire brs_route_s next_route;
	assign next_route.sel = next_sel;
	assign next_route.block = (next_sel == BRS_SEL_BOOTRAM) ? 3'd4 :
		(in_instruction_tcm || in_data_tcm || in_ahb) ? blk : BLK_NONE;
	assign next_route.offset = a[BLK_OFF_W - 1:0];
	assign next_route.chip_select = in_boot ? 4'h0 :
		(in_cs ? cs_num - CS_FIRST : 4'h0);
	assign next_route.cs_offset = a[CS_SHIFT - 1:0];
	assign next_route.hit = (next_sel != BRS_SEL_NONE);

	// one registered stage: decode ready one cycle after request
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			route_out <= '{BRS_SEL_NONE, BLK_NONE, 14'h0000, 4'h0,
				28'h000_0000, 1'b0};
			route_valid_out <= 1'b0;
		end else begin
			route_out <= next_route;
			route_valid_out <= req_valid_in && (state != BRS_ST_RESET);
		end
	end

	//------------------------------------------------------------
	// processor tcm port decode
	//------------------------------------------------------------
	wire logic [2:0] tcm_blk;
	brs_block_map u_tcm_map (
		.instruction_tcm_size_in(instruction_tcm_size_in),
		.data_tcm_size_in(data_tcm_size_in),
		.region_in(tcm_is_data_in ? 2'd1 : 2'd0),
		.slot_in({2'b00, tcm_addr_in[BLK_OFF_W]}),
		.block_out(tcm_blk)
	);

	// tcm hits answer in a single cycle at processor rate
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tcm_block_out <= BLK_NONE;
			tcm_offset_out <= 14'h0000;
			tcm_valid_out <= 1'b0;
		end else begin
			tcm_block_out <= tcm_blk;
			tcm_offset_out <= tcm_addr_in[BLK_OFF_W - 1:0];
			tcm_valid_out <= tcm_valid_in && tcm_blk != BLK_NONE;
		end
	end

	//------------------------------------------------------------
	// status and static controller default
	//------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			smc_cfg_out <= '{1'b1, SMC_WIDTH_16, 1'b1};
			boot_rom_out <= 1'b1;
			remap_out <= 1'b0;
		end else begin
			smc_cfg_out <= '{1'b1, SMC_WIDTH_16, 1'b1};
			boot_rom_out <= boot_rom;
			remap_out <= (next_state == BRS_ST_REMAP);
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	property p_ahb_keeps_block4;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(req_valid_in && a == AHB_BASE && state != BRS_ST_RESET) |=>
		(route_out.block == 3'd4 && route_out.sel == BRS_SEL_AHB);
	endproperty
	a_ahb_keeps_block4: assert property (p_ahb_keeps_block4)
		else $error("ahb base not on block 4");

	property p_reset_order;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(instruction_tcm_size_in == SIZE_0K && data_tcm_size_in == SIZE_0K &&
		(a & 32'hFFFF_C000) == 32'h0031_0000) |=>
		(route_out.block == 3'd0);
	endproperty
	a_reset_order: assert property (p_reset_order)
		else $error("reset layout top block wrong");

	property p_full_tcm;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(instruction_tcm_size_in == SIZE_32K && data_tcm_size_in == SIZE_32K &&
		a == 32'h0020_4000) |=> (route_out.block == 3'd2);
	endproperty
	a_full_tcm: assert property (p_full_tcm)
		else $error("data_tcm second slot wrong");

	property p_boot_pick;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(in_boot && state == BRS_ST_RUN) |=>
		(route_out.sel == (boot_rom ? BRS_SEL_ROM : BRS_SEL_EXT));
	endproperty
	a_boot_pick: assert property (p_boot_pick)
		else $error("boot memory choice wrong");

	property p_remap_ram;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(in_boot && state == BRS_ST_REMAP) |=>
		(route_out.sel == BRS_SEL_BOOTRAM);
	endproperty
	a_remap_ram: assert property (p_remap_ram)
		else $error("remap did not place sram at zero");

	property p_strap_hold;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		strap_valid |=> $stable(boot_rom);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("strap changed after capture");

	property p_sram16;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(req_valid_in && in_sram16 && state != BRS_ST_RESET) |=>
		(route_valid_out && route_out.sel == BRS_SEL_SRAM16);
	endproperty
	a_sram16: assert property (p_sram16)
		else $error("16 KB sram not decoded");

	property p_sysc;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(a[31:14] == 18'h3_FFFF) |=> (route_out.sel == BRS_SEL_SYSC);
	endproperty
	a_sysc: assert property (p_sysc)
		else $error("system controller window missed");

	property p_tcm_answer;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(tcm_valid_in && tcm_blk != BLK_NONE) |=>
		(tcm_valid_out && tcm_block_out == $past(tcm_blk));
	endproperty
	a_tcm_answer: assert property (p_tcm_answer)
		else $error("tcm hit not answered next cycle");

	property p_refuse_early;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(state == BRS_ST_RESET) |=> !route_valid_out;
	endproperty
	a_refuse_early: assert property (p_refuse_early)
		else $error("request answered before strap known");

	property p_remap_flag;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(state == BRS_ST_RUN && remap_in) |=> remap_out;
	endproperty
	a_remap_flag: assert property (p_remap_flag)
		else $error("remap state not shown");

	property p_rom_stays;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		in_rom |=> (route_out.sel == BRS_SEL_ROM);
	endproperty
	a_rom_stays: assert property (p_rom_stays)
		else $error("rom left its own base");

	property p_cs_window;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(a[31:28] == 4'h2) |=>
		(route_out.sel == BRS_SEL_OTHER && route_out.chip_select == 4'h1);
	endproperty
	a_cs_window: assert property (p_cs_window)
		else $error("chip select window decoded wrong");

	property p_ext_boot;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(in_boot && state == BRS_ST_RUN && !boot_rom) |=>
		(route_out.sel == BRS_SEL_EXT);
	endproperty
	a_ext_boot: assert property (p_ext_boot)
		else $error("external boot memory not at zero");
endmodule // brs_decoder
`default_nettype wire

// file: include/brs_pkg.sv
// package for the boot remap and sram allocation decoder
package brs_pkg;
	localparam int ADDR_W = 32;
	localparam int BLK_N = 5;
	localparam int BLK_IDX_W = 3;
	localparam int BLK_OFF_W = 14;
	localparam int PAGE_W = 18;
	localparam int SIZE_W = 2;
	localparam logic [31:0] BOOT_BASE = 32'h0000_0000;
	localparam logic [31:0] BOOT_LIMIT = 32'h000F_FFFF;
	localparam logic [31:0] INSTRUCTION_TCM_BASE = 32'h0010_0000;
	localparam logic [31:0] DATA_TCM_BASE = 32'h0020_0000;
	localparam logic [31:0] AHB_BASE = 32'h0030_0000;
	localparam logic [31:0] SRAM16_BASE = 32'h0050_0000;
	localparam logic [31:0] ROM_BASE = 32'h0040_0000;
	localparam logic [31:0] CS_BASE = 32'h1000_0000;
	localparam logic [31:0] SYSC_BASE = 32'hFFFF_C000;
	localparam logic [31:0] REGION_MASK = 32'hFFF0_0000;
	localparam logic [31:0] SYSC_MASK = 32'hFFFF_C000;
	localparam logic [31:0] CS_MASK = 32'hF000_0000;
	localparam logic [31:0] SRAM16_MASK = 32'hFFFF_C000;
	localparam int CS_SHIFT = 28;
	localparam logic [3:0] CS_FIRST = 4'h1;
	localparam logic [3:0] CS_LAST = 4'h8;
	localparam logic [1:0] SIZE_0K = 2'h0;
	localparam logic [1:0] SIZE_16K = 2'h1;
	localparam logic [1:0] SIZE_32K = 2'h2;
	localparam logic [2:0] BLK_NONE = 3'h7;
	localparam logic [1:0] SMC_WIDTH_16 = 2'h1;

	typedef enum logic [9:0] {
		BRS_SEL_NONE = 10'b00_0000_0001,
		BRS_SEL_ROM = 10'b00_0000_0010,
		BRS_SEL_EXT = 10'b00_0000_0100,
		BRS_SEL_INSTRUCTION_TCM = 10'b00_0000_1000,
		BRS_SEL_DATA_TCM = 10'b00_0001_0000,
		BRS_SEL_AHB = 10'b00_0010_0000,
		BRS_SEL_SRAM16 = 10'b00_0100_0000,
		BRS_SEL_SYSC = 10'b00_1000_0000,
		BRS_SEL_BOOTRAM = 10'b01_0000_0000,
		BRS_SEL_OTHER = 10'b10_0000_0000
	} brs_sel_e;

	typedef enum logic [2:0] {
		BRS_ST_RESET = 3'b001,
		BRS_ST_RUN = 3'b010,
		BRS_ST_REMAP = 3'b100
	} brs_state_e;

	typedef struct packed {
		brs_sel_e sel;
		logic [2:0] block;
		logic [13:0] offset;
		logic [3:0] chip_select;
		logic [27:0] cs_offset;
		logic hit;
	} brs_route_s;

	typedef struct packed {
		logic byte_select;
		logic [1:0] data_width;
		logic strobe_by_cs;
	} brs_smc_cfg_s;
endpackage : brs_pkg

// file: rtl/brs_block_map.sv
// steering of the five 16 KB sram blocks into instruction_tcm, data_tcm and ahb regions
`timescale 1ns/100ps
`default_nettype none
module brs_block_map
	import brs_pkg::*;
(
	input wire logic [1:0] instruction_tcm_size_in,
	input wire logic [1:0] data_tcm_size_in,
	input wire logic [1:0] region_in,
	input wire logic [2:0] slot_in,
	output logic [2:0] block_out
);
	// clip sizes to 32 KB; a reserved size code reads as 32 KB
	wire logic [2:0] n_instruction_tcm;
	wire logic [2:0] n_data_tcm;
	wire logic [2:0] n_ahb;
	assign n_instruction_tcm = (instruction_tcm_size_in >= SIZE_32K) ? 3'd2 : {1'b0, instruction_tcm_size_in};
	assign n_data_tcm = (data_tcm_size_in >= SIZE_32K) ? 3'd2 : {1'b0, data_tcm_size_in};
	assign n_ahb = 3'(BLK_N) - n_instruction_tcm - n_data_tcm;

	// instruction_tcm takes blocks 1,0; data_tcm 3,2; ahb gets block 4 then the leftovers
	// from high to low, so blocks move without staying contiguous
	always_comb begin
		block_out = BLK_NONE;
		case (region_in)
			2'd0: begin
				if (slot_in < n_instruction_tcm)
					block_out = 3'd1 - slot_in;
			end
			2'd1: begin
				if (slot_in < n_data_tcm)
					block_out = 3'd3 - slot_in;
			end
			2'd2: begin
				if (slot_in == 3'd0)
					block_out = 3'd4;
				else if (slot_in < n_ahb) begin
					// free high blocks skip those data_tcm holds
					if (slot_in <= 3'd2 - n_data_tcm)
						block_out = 3'd4 - n_data_tcm - slot_in;
					else // free low blocks skip those instruction_tcm holds
						block_out = 3'd1 - n_instruction_tcm -
							(slot_in - (3'd3 - n_data_tcm));
				end
			end
			default: block_out = BLK_NONE;
		endcase
	end
endmodule // brs_block_map
`default_nettype wire

// file: rtl/brs_boot_latch.sv
// boot select strap capture at reset release
`timescale 1ns/100ps
`default_nettype none
module brs_boot_latch (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic boot_select_pin_in,
	output logic boot_rom_out,
	output logic valid_out
);
	// strap caught on the first clocked edge after release, then frozen
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot_rom_out <= 1'b1;
			valid_out <= 1'b0;
		end else if (!valid_out) begin
			boot_rom_out <= boot_select_pin_in;
			valid_out <= 1'b1;
		end
	end
endmodule // brs_boot_latch
`default_nettype wire

// file: bench/brs_master_model.sv
// bus-matrix master and tcm port model facing the decoder
`timescale 1ns/100ps
`default_nettype none
module brs_master_model (
	input wire logic core_clk_in,
	output logic req_valid_out,
	output logic [31:0] req_addr_out,
	output logic tcm_valid_out,
	output logic tcm_is_data_out,
	output logic [15:0] tcm_addr_out,
	output logic remap_out
);
	// quiet start: nothing requested, remap clear until software boots
	initial begin
		req_valid_out = 1'b0;
		req_addr_out = 32'h0000_0000;
		tcm_valid_out = 1'b0;
		tcm_is_data_out = 1'b0;
		tcm_addr_out = 16'h0000;
		remap_out = 1'b0;
	end

	// an idle bus shows the inverse, so a stale address never matches
	task automatic mreq(input logic v, input logic [31:0] a);
		@(posedge core_clk_in);
		req_valid_out <= v;
		req_addr_out <= v ? a : ~req_addr_out;
	endtask

	// tcm port request, one per edge
	task automatic treq(input logic v, input logic d, input logic [15:0] a);
		@(posedge core_clk_in);
		tcm_valid_out <= v;
		tcm_is_data_out <= d;
		tcm_addr_out <= v ? a : ~tcm_addr_out;
	endtask

	// software remap, issued only after boot has run
	task automatic remap(input logic v);
		@(posedge core_clk_in);
		remap_out <= v;
	endtask
endmodule // brs_master_model
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the boot remap and sram decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import brs_pkg::*;
;
	typedef struct {
		logic [1:0] it;
		logic [1:0] dt;
		logic [31:0] a;
		brs_sel_e sel;
		logic [2:0] blk;
	} brs_row_s;
	logic clk, rst_n, pin, rq_v, tc_v, tc_d, rmp, rt_v, tb_v, brom, rmp_o;
	logic [1:0] it, dt;
	logic [31:0] rq_a;
	logic [15:0] tc_a;
	logic [2:0] tb_blk;
	logic [13:0] tb_off;
	brs_route_s rt;
	brs_smc_cfg_s static_memory_controller;
	int miscompares = 0;
	int tests_run = 0;
	// blk 7 marks rows whose block field is not looked at
	brs_row_s rows [0:23] = '{
		'{2'h0, 2'h0, 32'h0030_0000, BRS_SEL_AHB, 3'h4},
		'{2'h0, 2'h0, 32'h0030_4000, BRS_SEL_AHB, 3'h3},
		'{2'h0, 2'h0, 32'h0030_8010, BRS_SEL_AHB, 3'h2},
		'{2'h0, 2'h0, 32'h0030_C000, BRS_SEL_AHB, 3'h1},
		'{2'h0, 2'h0, 32'h0031_0004, BRS_SEL_AHB, 3'h0},
		'{2'h2, 2'h2, 32'h0010_0000, BRS_SEL_INSTRUCTION_TCM, 3'h1},
		'{2'h2, 2'h2, 32'h0010_4020, BRS_SEL_INSTRUCTION_TCM, 3'h0},
		'{2'h2, 2'h2, 32'h0020_0000, BRS_SEL_DATA_TCM, 3'h3},
		'{2'h2, 2'h2, 32'h0020_4000, BRS_SEL_DATA_TCM, 3'h2},
		'{2'h2, 2'h2, 32'h0030_0000, BRS_SEL_AHB, 3'h4},
		'{2'h2, 2'h2, 32'h0030_4000, BRS_SEL_NONE, 3'h7},
		'{2'h1, 2'h2, 32'h0010_0000, BRS_SEL_INSTRUCTION_TCM, 3'h1},
		'{2'h1, 2'h2, 32'h0030_4000, BRS_SEL_AHB, 3'h0},
		'{2'h2, 2'h1, 32'h0010_4000, BRS_SEL_INSTRUCTION_TCM, 3'h0},
		'{2'h2, 2'h1, 32'h0020_0008, BRS_SEL_DATA_TCM, 3'h3},
		'{2'h2, 2'h1, 32'h0030_4000, BRS_SEL_AHB, 3'h2},
		'{2'h1, 2'h1, 32'h0030_4000, BRS_SEL_AHB, 3'h2},
		'{2'h1, 2'h1, 32'h0030_8000, BRS_SEL_AHB, 3'h0},
		'{2'h1, 2'h1, 32'h1000_0000, BRS_SEL_OTHER, 3'h7},
		'{2'h1, 2'h1, 32'h0050_0000, BRS_SEL_SRAM16, 3'h7},
		'{2'h1, 2'h1, 32'h0040_0000, BRS_SEL_ROM, 3'h7},
		'{2'h1, 2'h1, 32'hFFFF_C000, BRS_SEL_SYSC, 3'h7},
		'{2'h1, 2'h1, 32'h000F_FFFC, BRS_SEL_ROM, 3'h7},
		'{2'h1, 2'h1, 32'h0000_0000, BRS_SEL_ROM, 3'h7}};

	brs_master_model i_master (.core_clk_in(clk), .req_valid_out(rq_v),
		.req_addr_out(rq_a), .tcm_valid_out(tc_v), .tcm_is_data_out(tc_d),
		.tcm_addr_out(tc_a), .remap_out(rmp));
	brs_decoder i_dut (.core_clk_in(clk), .rst_n_in(rst_n),
		.boot_select_pin_in(pin), .remap_in(rmp), .instruction_tcm_size_in(it),
		.data_tcm_size_in(dt), .req_valid_in(rq_v), .req_addr_in(rq_a),
		.tcm_valid_in(tc_v), .tcm_is_data_in(tc_d), .tcm_addr_in(tc_a),
		.route_out(rt), .route_valid_out(rt_v), .tcm_block_out(tb_blk),
		.tcm_offset_out(tb_off), .tcm_valid_out(tb_v), .smc_cfg_out(static_memory_controller),
		.boot_rom_out(brom), .remap_out(rmp_o));

	// 20 MHz core clock
	always #25 clk = ~clk;

	// ------------------------------------------------------------
	// check helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// one matrix request, answer looked at in its single cycle
	task automatic mchk(input logic [31:0] a, input brs_sel_e s,
		input logic [2:0] b);
		i_master.mreq(1'b1, a);
		i_master.mreq(1'b0, 32'h0000_0000);
		@(negedge clk);
		chk(32'(rt_v), 32'h1);
		chk(32'(rt.sel), 32'(s));
		chk(32'(rt.hit), 32'(s != BRS_SEL_NONE));
		if (b != 3'h7) begin
			chk(32'(rt.block), 32'(b));
			chk(32'(rt.offset), 32'(a[13:0]));
		end
		@(negedge clk);
		chk(32'(rt_v), 32'h0);
	endtask

	// tcm port request; v says whether the size admits it
	task automatic tchk(input logic d, input logic [15:0] a,
		input logic [2:0] b, input logic v);
		i_master.treq(1'b1, d, a);
		i_master.treq(1'b0, 1'b0, 16'h0000);
		@(negedge clk);
		chk(32'(tb_v), 32'(v));
		if (v) begin
			chk(32'(tb_blk), 32'(b));
			chk(32'(tb_off), 32'(a[13:0]));
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under 1000 cycles
	initial begin
		#(50 * 4000);
		miscompares++;
		test_done();
	end

	// main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		pin = 1'b1;
		it = 2'h0;
		dt = 2'h0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		chk(32'(rt_v), 32'h0);
		chk(32'(rmp_o), 32'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		pin <= 1'b0;
		// strap change after release must not leak through
		foreach (rows[i]) begin
			@(posedge clk);
			it <= rows[i].it;
			dt <= rows[i].dt;
			mchk(rows[i].a, rows[i].sel, rows[i].blk);
		end
		chk(32'(brom), 32'h1);
		// tcm ports with 32K/32K, then a refused address at 16K
		@(posedge clk);
		it <= SIZE_32K;
		dt <= SIZE_32K;
		tchk(1'b0, 16'h0004, 3'h1, 1'b1);
		tchk(1'b0, 16'h4000, 3'h0, 1'b1);
		tchk(1'b1, 16'h4010, 3'h2, 1'b1);
		@(posedge clk);
		it <= SIZE_16K;
		tchk(1'b0, 16'h4000, 3'h0, 1'b0);
		// back to back across a chip-select window boundary
		i_master.mreq(1'b1, 32'h1FFF_FFFC);
		i_master.mreq(1'b1, 32'h2000_0004);
		@(negedge clk);
		chk(32'(rt.chip_select), 32'h0);
		chk(32'(rt.cs_offset), 32'h0FFF_FFFC);
		i_master.mreq(1'b0, 32'h0000_0000);
		@(negedge clk);
		chk(32'(rt.chip_select), 32'h1);
		chk(32'(rt.cs_offset), 32'h0000_0004);
		// remap puts internal sram at zero, other memories stay
		i_master.remap(1'b1);
		repeat (2) @(posedge clk);
		mchk(32'h0000_0000, BRS_SEL_BOOTRAM, 3'h4);
		chk(32'(rmp_o), 32'h1);
		// cs0 timing stays at its boot default: retiming is software's job
		chk(32'(static_memory_controller), 32'h0000_000B);
		mchk(ROM_BASE, BRS_SEL_ROM, 3'h7);
		mchk(SRAM16_BASE, BRS_SEL_SRAM16, 3'h7);
		i_master.remap(1'b0);
		repeat (2) @(posedge clk);
		mchk(32'h0000_0010, BRS_SEL_ROM, 3'h7);
		// second reset with the strap low: external boot
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// a request in the strap capture cycle is refused
		i_master.mreq(1'b1, AHB_BASE);
		i_master.mreq(1'b0, 32'h0000_0000);
		@(negedge clk);
		chk(32'(rt_v), 32'h0);
		@(negedge clk);
		chk(32'(brom), 32'h0);
		mchk(32'h0000_0000, BRS_SEL_EXT, 3'h7);
		// cs window then boot area back to back: cs0 must not go stale
		i_master.mreq(1'b1, 32'h3000_0000);
		i_master.mreq(1'b1, 32'h0000_0000);
		@(negedge clk);
		chk(32'(rt.chip_select), 32'h2);
		i_master.mreq(1'b0, 32'h0000_0000);
		@(negedge clk);
		chk(32'(rt.sel), 32'(BRS_SEL_EXT));
		chk(32'(rt.chip_select), 32'h0);
		chk(32'(static_memory_controller.byte_select), 32'h1);
		chk(32'(static_memory_controller.data_width), 32'(SMC_WIDTH_16));
		chk(32'(static_memory_controller.strobe_by_cs), 32'h1);
		mchk(ROM_BASE, BRS_SEL_ROM, 3'h7);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
